//--- rtl/ewps_pkg.sv
// Constants for the EEPROM write-protect and status block.
// Assumes an SPI mode-0 host; the system clock oversamples the serial pins.
// Notes on behaviour
// - Internal write completes only if the write enable latch was set at request.
// - Enable command sets latch, disable command clears it, regardless of protection.
// - Latch clears at power-up and after disable, accepted status write or accepted array write.
// - Read-status returns the status byte anytime, even during an internal write.
// - Status bit 0 is busy: one during internal write, read-only.
// - Status bit 1 mirrors the write enable latch, read-only.
// - Bits 3 and 2 are block-protect, nonvolatile, changed only by status write.
// - Status write updates only bits 7, 3, 2; bits 1 and 0 stay read-only.
// - Block-protect 00 none, 01 upper quarter, 10 upper half, 11 all; always enforced.
// - Status bit 7 enables the effect of the write-protect pin.
// - Hardware protection active only when pin low and bit 7 set.
// - Hardware protection blocks only status writes; unprotected array writes still allowed.
// - Internal write starts only if select rises after a whole byte count.
// - Array access during an internal write is ignored; programming continues.
// - Power-on: standby, deselected, latch clear, serial output high impedance.
// - Opcodes: enable 06, disable 04, read status 05, write status 01.
// - Latch sets only when select rises after all eight enable bits.
// - MSB first; sample on rising clock, update output after falling clock.
package ewps_pkg;
   localparam logic [7:0] EWPS_OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] EWPS_OP_WRITE_ARRAY = 8'h02;
   localparam logic [7:0] EWPS_OP_READ_ARRAY = 8'h03;
   localparam logic [7:0] EWPS_OP_DISABLE = 8'h04;
   localparam logic [7:0] EWPS_OP_READ_STATUS = 8'h05;
   localparam logic [7:0] EWPS_OP_ENABLE = 8'h06;
   localparam int EWPS_BIT_BUSY = 0;
   localparam int EWPS_BIT_LATCH = 1;
   localparam int EWPS_BIT_BP_LOW = 2;
   localparam int EWPS_BIT_BP_HIGH = 3;
   localparam int EWPS_BIT_PIN_EN = 7;
   localparam logic [7:0] EWPS_NV_MASK = 8'h8c;
   localparam logic [11:0] EWPS_QUARTER_BASE = 12'hc00;
   localparam logic [11:0] EWPS_HALF_BASE = 12'h800;
   localparam logic [1:0] EWPS_BP_NONE = 2'h0;
   localparam logic [1:0] EWPS_BP_QUARTER = 2'h1;
   localparam logic [1:0] EWPS_BP_HALF = 2'h2;
   localparam logic [5:0] EWPS_WRITE_ADDR_BITS = 6'h18;
   localparam logic [5:0] EWPS_BYTE_BITS = 6'h08;
   localparam int EWPS_CLK_MHZ = 125;
   localparam int EWPS_WRITE_TIME_US = 5000;
   localparam int EWPS_WRITE_CYCLES = EWPS_WRITE_TIME_US * EWPS_CLK_MHZ;
endpackage

//--- rtl/ewps_sync.sv
// Two-flop synchroniser for the serial pins.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/10ps
module ewps_sync #(
   parameter int WIDTH = 4
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   input wire logic [WIDTH-1:0] i_rst_val,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ewps_sync_t;
   ewps_sync_t st_q;
   ewps_sync_t st_d;
   logic unused_rst;

   assign unused_rst = ^i_rst_val;

   always_comb
   begin
      st_d.meta = i_async;
      st_d.sync = st_q.meta;
   end

   // Reset takes constant ones so select and pins idle high
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_q <= '1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.sync;
endmodule

//--- rtl/ewps_top.sv
// Write-protect and status logic of a serial EEPROM, SPI mode 0.
// Assumes i_clk far faster than the serial clock; array engine sits outside.
`timescale 1ns/10ps
module ewps_top #(
   parameter int WRITE_CYCLES = ewps_pkg::EWPS_WRITE_CYCLES,
   parameter logic [7:0] NV_RESET = 8'h00
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_busy_flag,
   output logic o_latch_flag,
   output logic [7:0] o_protection_status,
   output logic o_array_write_start,
   output logic [11:0] o_array_write_addr,
   output logic o_array_write_refused
);
   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [1:0] {EWPS_S_CMD, EWPS_S_BODY, EWPS_S_IGNORE} ewps_phase_t;

   typedef struct packed
   {
      ewps_phase_t phase;
      logic [7:0] opcode;
      logic [23:0] shift;
      logic [5:0] bit_cnt;
      logic [15:0] addr;
      logic [7:0] out_byte;
      logic [2:0] out_idx;
      logic so;
      logic so_oe;
      logic sck_prev;
      logic cs_prev;
      logic latch_flag;
      logic [7:0] nv_bits;
      logic nv_loaded;
      logic busy;
      logic [31:0] busy_cnt;
      logic whole_byte;
      logic data_seen;
      logic wr_start;
      logic wr_refused;
      logic [11:0] wr_addr;
   } ewps_state_t;

   ewps_state_t st_q;
   ewps_state_t st_d;
   logic [3:0] pins;
   logic sck;
   logic cs_n;
   logic si;
   logic wp_n;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;
   logic [7:0] status;
   logic hw_protect;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   ewps_sync #(.WIDTH(4)) u_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async({i_sck, i_cs_n, i_si, i_wp_n}),
      .i_rst_val(4'hf),
      .o_sync(pins)
   );

   assign sck = pins[3];
   assign cs_n = pins[2];
   assign si = pins[1];
   assign wp_n = pins[0];

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic blk_prot(input logic [1:0] bp, input logic [11:0] a);
      logic r;
      r = 1'b1;
      if (bp == ewps_pkg::EWPS_BP_NONE)
      begin
         r = 1'b0;
      end
      else if (bp == ewps_pkg::EWPS_BP_QUARTER)
      begin
         r = (a >= ewps_pkg::EWPS_QUARTER_BASE);
      end
      else if (bp == ewps_pkg::EWPS_BP_HALF)
      begin
         r = (a >= ewps_pkg::EWPS_HALF_BASE);
      end
      return r;
   endfunction

   assign sck_rise = sck & ~st_q.sck_prev & ~cs_n;
   assign sck_fall = ~sck & st_q.sck_prev & ~cs_n;
   assign cs_rise = cs_n & ~st_q.cs_prev;
   assign cs_fall = ~cs_n & st_q.cs_prev;

   // Bits 6..4 read zero
   always_comb
   begin
      status = 8'h00;
      status[ewps_pkg::EWPS_BIT_PIN_EN] = st_q.nv_bits[ewps_pkg::EWPS_BIT_PIN_EN];
      status[ewps_pkg::EWPS_BIT_BP_HIGH] = st_q.nv_bits[ewps_pkg::EWPS_BIT_BP_HIGH];
      status[ewps_pkg::EWPS_BIT_BP_LOW] = st_q.nv_bits[ewps_pkg::EWPS_BIT_BP_LOW];
      status[ewps_pkg::EWPS_BIT_LATCH] = st_q.latch_flag;
      status[ewps_pkg::EWPS_BIT_BUSY] = st_q.busy;
   end

   assign hw_protect = ~wp_n & st_q.nv_bits[ewps_pkg::EWPS_BIT_PIN_EN];

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic [23:0] sh;
      logic [11:0] a;
      sh = '0;
      a = '0;
      st_d = st_q;
      st_d.sck_prev = sck;
      st_d.cs_prev = cs_n;
      st_d.wr_start = 1'b0;
      st_d.wr_refused = 1'b0;
      // Strap-free nonvolatile model: load default once after reset
      if (!st_q.nv_loaded)
      begin
         st_d.nv_bits = NV_RESET & ewps_pkg::EWPS_NV_MASK;
         st_d.nv_loaded = 1'b1;
      end
      // Self-timed cycle runs regardless of bus activity
      if (st_q.busy)
      begin
         if (st_q.busy_cnt == 32'(WRITE_CYCLES - 1))
         begin
            st_d.busy = 1'b0;
            st_d.busy_cnt = '0;
         end
         else
         begin
            st_d.busy_cnt = st_q.busy_cnt + 32'h1;
         end
      end
      if (cs_fall)
      begin
         st_d.phase = EWPS_S_CMD;
         st_d.bit_cnt = '0;
         st_d.shift = '0;
         st_d.data_seen = 1'b0;
         st_d.whole_byte = 1'b0;
         st_d.so_oe = 1'b0;
      end
      if (sck_rise)
      begin
         sh = {st_q.shift[22:0], si};
         st_d.shift = sh;
         st_d.bit_cnt = st_q.bit_cnt + 6'h1;
         case (st_q.phase)
            EWPS_S_CMD:
            begin
               if (st_q.bit_cnt == ewps_pkg::EWPS_BYTE_BITS - 6'h1)
               begin
                  st_d.opcode = sh[7:0];
                  st_d.bit_cnt = '0;
                  st_d.whole_byte = 1'b1;
                  st_d.phase = EWPS_S_BODY;
                  if (sh[7:0] == ewps_pkg::EWPS_OP_READ_STATUS)
                  begin
                     st_d.out_byte = status;
                     st_d.out_idx = 3'h7;
                  end
                  else if (st_q.busy && sh[7:0] != ewps_pkg::EWPS_OP_ENABLE
                           && sh[7:0] != ewps_pkg::EWPS_OP_DISABLE)
                  begin
                     st_d.phase = EWPS_S_IGNORE;
                  end
               end
               else
               begin
                  st_d.whole_byte = 1'b0;
               end
            end
            EWPS_S_BODY:
            begin
               st_d.whole_byte = 1'b0;
               if (st_q.opcode == ewps_pkg::EWPS_OP_WRITE_ARRAY)
               begin
                  if (st_q.bit_cnt == ewps_pkg::EWPS_WRITE_ADDR_BITS - 6'h1)
                  begin
                     // First data byte completes together with the address
                     st_d.addr = sh[23:8];
                     st_d.bit_cnt = ewps_pkg::EWPS_WRITE_ADDR_BITS;
                     st_d.data_seen = 1'b1;
                     st_d.whole_byte = 1'b1;
                  end
                  else if (st_q.bit_cnt == ewps_pkg::EWPS_WRITE_ADDR_BITS + ewps_pkg::EWPS_BYTE_BITS - 6'h1)
                  begin
                     st_d.bit_cnt = ewps_pkg::EWPS_WRITE_ADDR_BITS;
                     st_d.data_seen = 1'b1;
                     st_d.whole_byte = 1'b1;
                  end
               end
               else if (st_q.bit_cnt == ewps_pkg::EWPS_BYTE_BITS - 6'h1)
               begin
                  st_d.bit_cnt = '0;
                  st_d.data_seen = 1'b1;
                  st_d.whole_byte = 1'b1;
                  st_d.out_byte = status;
                  st_d.out_idx = 3'h7;
               end
            end
            default:
            begin
               st_d.bit_cnt = '0;
            end
         endcase
      end
      if (sck_fall && st_q.phase == EWPS_S_BODY && st_q.opcode == ewps_pkg::EWPS_OP_READ_STATUS)
      begin
         st_d.so = st_q.out_byte[st_q.out_idx];
         st_d.so_oe = 1'b1;
         st_d.out_idx = st_q.out_idx - 3'h1;
      end
      if (cs_rise)
      begin
         st_d.so_oe = 1'b0;
         st_d.phase = EWPS_S_CMD;
         st_d.bit_cnt = '0;
         if (st_q.phase == EWPS_S_BODY && st_q.whole_byte)
         begin
            case (st_q.opcode)
               ewps_pkg::EWPS_OP_ENABLE:
               begin
                  if (!st_q.data_seen)
                  begin
                     st_d.latch_flag = 1'b1;
                  end
               end
               ewps_pkg::EWPS_OP_DISABLE:
               begin
                  if (!st_q.data_seen)
                  begin
                     st_d.latch_flag = 1'b0;
                  end
               end
               ewps_pkg::EWPS_OP_WRITE_STATUS:
               begin
                  if (st_q.data_seen && st_q.latch_flag && !hw_protect)
                  begin
                     st_d.nv_bits = st_q.shift[7:0] & ewps_pkg::EWPS_NV_MASK;
                     st_d.latch_flag = 1'b0;
                     st_d.busy = 1'b1;
                     st_d.busy_cnt = '0;
                  end
               end
               ewps_pkg::EWPS_OP_WRITE_ARRAY:
               begin
                  a = st_q.addr[11:0];
                  if (st_q.data_seen && st_q.latch_flag
                      && !blk_prot(st_q.nv_bits[3:2], a))
                  begin
                     st_d.latch_flag = 1'b0;
                     st_d.busy = 1'b1;
                     st_d.busy_cnt = '0;
                     st_d.wr_start = 1'b1;
                     st_d.wr_addr = a;
                  end
                  else if (st_q.data_seen)
                  begin
                     st_d.wr_refused = 1'b1;
                  end
               end
               default:
               begin
                  st_d.phase = EWPS_S_CMD;
               end
            endcase
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_q <= '0;
         st_q.sck_prev <= 1'b1;
         st_q.cs_prev <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_so = st_q.so;
   assign o_so_oe = st_q.so_oe;
   assign o_busy_flag = st_q.busy;
   assign o_latch_flag = st_q.latch_flag;
   assign o_protection_status = status;
   assign o_array_write_start = st_q.wr_start;
   assign o_array_write_addr = st_q.wr_addr;
   assign o_array_write_refused = st_q.wr_refused;
endmodule

//--- test/ewps_top_asserts.sv
// Concurrent checks of the write-protect and status block.
// Sees only the ewps_top ports; bound to every instance of it.
`timescale 1ns/10ps
module ewps_top_asserts #(
   parameter int WRITE_CYCLES = 2000
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_wp_n,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic o_busy_flag,
   input wire logic o_latch_flag,
   input wire logic [7:0] o_protection_status,
   input wire logic o_array_write_start,
   input wire logic [11:0] o_array_write_addr,
   input wire logic o_array_write_refused
);
   // ****************************************
   // Busy length counter
   // ****************************************
   logic [31:0] busy_cnt_q;
   logic [1:0] bp;
   assign bp = o_protection_status[3:2];
   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
         busy_cnt_q <= 32'h0;
      else
         busy_cnt_q <= o_busy_flag ? busy_cnt_q + 32'h1 : 32'h0;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   property p_latch_bit;
      o_protection_status[1] == o_latch_flag;
   endproperty
   a_latch_bit: assert property (p_latch_bit) else $error("latch bit differs");
   property p_busy_bit;
      o_protection_status[0] == o_busy_flag;
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit differs");
   property p_unused;
      o_protection_status[6:4] == 3'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
   property p_start_latch;
      o_array_write_start |-> $past(o_latch_flag);
   endproperty
   a_start_latch: assert property (p_start_latch) else $error("start without latch");
   property p_block;
      o_array_write_start |-> !(bp == 2'h3 || (bp == 2'h2 && o_array_write_addr[11])
         || (bp == 2'h1 && o_array_write_addr[11:10] == 2'h3));
   endproperty
   a_block: assert property (p_block) else $error("protected block written");
   property p_start_effects;
      o_array_write_start |-> ##[0:4] (o_busy_flag && !o_latch_flag);
   endproperty
   a_start_effects: assert property (p_start_effects) else $error("no busy or latch kept");
   property p_nv_change;
      !$stable({o_protection_status[7], bp}) |-> $past(o_latch_flag);
   endproperty
   a_nv_change: assert property (p_nv_change) else $error("nv bits changed unasked");
   property p_oe_idle;
      i_cs_n [*8] |-> !o_so_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("output driven deselected");
   property p_busy_len;
      busy_cnt_q <= 32'(WRITE_CYCLES + 8);
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy too long");
   c_start: cover property (o_array_write_start);
   c_refused: cover property (o_array_write_refused);
   c_read: cover property (o_so_oe && o_busy_flag);
endmodule
bind ewps_top ewps_top_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.i_clk(i_clk), .i_reset(i_reset),
   .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe),
   .o_busy_flag(o_busy_flag), .o_latch_flag(o_latch_flag), .o_protection_status(o_protection_status),
   .o_array_write_start(o_array_write_start), .o_array_write_addr(o_array_write_addr),
   .o_array_write_refused(o_array_write_refused));

//--- test/ewps_host.sv
// Behavioural SPI mode-0 host that drives the serial pins.
// Assumes it is called on a falling edge of i_clk; serial clock period 8 i_clk.
`timescale 1ns/10ps
module ewps_host
(
   input wire logic i_clk,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si
);
   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   task automatic half();
      repeat (4) @(negedge i_clk);
   endtask
   // Left-aligned frame; reply is the last eight bits seen
   task automatic frame(input logic [39:0] d, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      o_cs_n = 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         o_si = d[39-i];
         half();
         o_sck = 1'b1;
         half();
         // Late sample; undriven output reads unknown so it cannot match
         rx = {rx[6:0], i_so_oe ? i_so : 1'bx};
         o_sck = 1'b0;
      end
      half();
      o_cs_n = 1'b1;
      o_si = ~o_si;
      half();
      half();
   endtask
endmodule

//--- test/ewps_top_tb.sv
// Self-checking bench of the write-protect and status block.
// Assumes ewps_host as the serial host and the bound checker.
`timescale 1ns/10ps
module ewps_top_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wp_n = 1'b1;
   logic sck, cs_n, si, so, so_oe, busy, latch, start, refused;
   logic [7:0] st, rx;
   logic [11:0] waddr;
   logic [11:0] addrs [6] = '{12'h000, 12'h7ff, 12'h800, 12'hbff, 12'hc00, 12'hfff};
   int n_errors = 0;
   int checks_done = 0;
   int n_start = 0;
   int n_ref = 0;
   always #4 clk = ~clk;
   ewps_top #(.WRITE_CYCLES(2000)) u_dut (.i_clk(clk), .i_reset(reset), .i_sck(sck), .i_cs_n(cs_n),
      .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_busy_flag(busy), .o_latch_flag(latch),
      .o_protection_status(st), .o_array_write_start(start), .o_array_write_addr(waddr),
      .o_array_write_refused(refused));
   ewps_host u_host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
   always @(posedge clk)
   begin
      if (start === 1'b1)
         n_start++;
      if (refused === 1'b1)
         n_ref++;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic tally_and_finish();
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic cmd(input logic [39:0] d, input int nb);
      u_host.frame(d, nb, rx);
   endtask
   task automatic en();
      cmd({8'h06, 32'h0}, 8);
   endtask
   task automatic read_status(input logic [7:0] exp);
      cmd({8'h05, 32'h0}, 16);
      chk(rx, exp, "status");
      chk(st, exp, "status port");
   endtask
   task automatic write_status(input logic [7:0] v);
      cmd({8'h01, v, 24'h0}, 16);
   endtask
   task automatic arr(input logic [11:0] a, input int nb);
      cmd({8'h02, 4'h0, a, 8'h5a, 8'h0}, nb);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++)
         @(negedge clk);
      chk(busy, 1'b0, "busy end");
   endtask
   function automatic logic prot(input logic [1:0] bp, input logic [11:0] a);
      return bp == 2'h3 || (bp == 2'h2 && a[11]) || (bp == 2'h1 && a[11:10] == 2'h3);
   endfunction
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (6) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      chk({so_oe, latch, busy}, 3'h0, "power-on");
      read_status(8'h00);
      cmd({8'h06, 8'h02, 4'h0, 12'h000, 8'h5a}, 40);
      chk(latch, 1'b0, "latch in frame");
      write_status(8'h8c);
      read_status(8'h00);
      en();
      read_status(8'h02);
      cmd({8'h04, 32'h0}, 8);
      chk(latch, 1'b0, "disable");
      en();
      write_status(8'hff);
      read_status(8'h8d);
      wait_idle();
      read_status(8'h8c);
      wp_n = 1'b0;
      en();
      write_status(8'h00);
      read_status(8'h8e);
      wp_n = 1'b1;
      write_status(8'h00);
      wait_idle();
      wp_n = 1'b0;
      en();
      write_status(8'h0c);
      wait_idle();
      read_status(8'h0c);
      for (int b = 0; b < 4; b++)
      begin
         wp_n = 1'b1;
         en();
         write_status({1'b1, 3'h0, 2'(b), 2'h0});
         wait_idle();
         wp_n = 1'b0;
         foreach (addrs[k])
         begin
            n_start = 0;
            n_ref = 0;
            en();
            arr(addrs[k], 32);
            chk({n_start[1:0], n_ref[1:0]}, prot(2'(b), addrs[k]) ? 4'h1 : 4'h4, "array");
            if (!prot(2'(b), addrs[k]))
               chk({waddr, latch}, {addrs[k], 1'b0}, "write addr");
            wait_idle();
            cmd({8'h04, 32'h0}, 8);
         end
      end
      wp_n = 1'b1;
      en();
      write_status(8'h00);
      wait_idle();
      n_start = 0;
      n_ref = 0;
      en();
      arr(12'h010, 31);
      chk({n_start[1:0], n_ref[1:0]}, 4'h0, "partial");
      en();
      arr(12'h020, 32);
      en();
      arr(12'h030, 32);
      chk({n_start[1:0], busy}, 3'h3, "during busy");
      wait_idle();
      tally_and_finish();
   end
   initial
   begin
      #700000;
      n_errors++;
      tally_and_finish();
   end
endmodule
